// [rtl/fpac_defs.vh]
`ifndef FPAC_DEFS_VH
`define FPAC_DEFS_VH

// operation select on the issue port
`define FPAC_OP_ABS    2'h0
`define FPAC_OP_ADD    2'h1
`define FPAC_OP_CEQ    2'h2
`define FPAC_OP_CGT    2'h3

// execution states per operation
`define FPAC_LAT_ONE   3'h1
`define FPAC_LAT_ADDD  3'h6
`define FPAC_LAT_CGT   3'h2

// operand classes
`define FPAC_C_NORM    3'h0
`define FPAC_C_PZERO   3'h1
`define FPAC_C_NZERO   3'h2
`define FPAC_C_PINF    3'h3
`define FPAC_C_NINF    3'h4
`define FPAC_C_DENORM  3'h5
`define FPAC_C_QNAN    3'h6
`define FPAC_C_SNAN    3'h7

// fp_status_control layout
`define FPAC_SC_PR     0
`define FPAC_SC_DN     1
`define FPAC_SC_EN     2
`define FPAC_SC_FLAG   7
`define FPAC_SC_CAUSE  12
`define FPAC_SC_W      18
`define FPAC_SC_RST    18'h00000

// exception bit positions inside enable, flag and cause groups; E only in cause
`define FPAC_X_I       0
`define FPAC_X_U       1
`define FPAC_X_O       2
`define FPAC_X_V       4
`define FPAC_X_E       5

// register map, byte addresses
`define FPAC_A_FR_TOP  8'h3c
`define FPAC_A_CTRL    8'h40
`define FPAC_A_IRQ_ST  8'h44
`define FPAC_A_IRQ_CLR 8'h48
`define FPAC_A_IRQ_EN  8'h4c

// interrupt status bits
`define FPAC_IRQ_W     3
`define FPAC_IRQ_TRAP  0
`define FPAC_IRQ_INV   1
`define FPAC_IRQ_ERR   2

// special values
`define FPAC_QNAN_S    32'h7fbfffff
`define FPAC_QNAN_D    64'h7ff7ffffffffffff
`define FPAC_SIGN_CLR  64'h7fffffffffffffff
`define FPAC_EMAX_D    13'h07ff
`define FPAC_EMAX_S    13'h00ff

`endif

// [rtl/fpac_unit.v]
// Overview of operation
// - absolute value clears sign of single or double operand, one state.
// - absolute value leaves cause and flags alone and never raises exceptions.
// - single add sums two single registers into destination in one state.
// - double add sums two register pairs into destination pair in six states.
// - any overflow, underflow or inexact enable set makes add always trap.
// - on add trap record cause and flags, leave destination unwritten.
// - signalling NaN in add gives invalid, checked before all else.
// - otherwise a quiet NaN operand gives a quiet NaN result.
// - otherwise a denormal operand raises the FPU error condition.
// - positive zero source plus negative zero destination writes positive zero.
// - denorm flush set treats denormals as zero in add and compare.
// - compare-equal sets test flag on equality, one state.
// - compare-greater sets test flag when destination exceeds source, two states.
// - positive and negative zero compare equal.
// - invalid compare sets invalid cause; flag 0 unless enabled, then trap.
// - compare-greater also goes invalid on quiet NaN.
// - unordered compare counts as not greater.
`timescale 1ns/100ps
`include "fpac_defs.vh"

module fpac_unit (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  input  wire        op_valid_i,
  input  wire [1:0]  op_code_i,
  input  wire [3:0]  op_dst_i,
  input  wire [3:0]  op_src_i,
  output wire        op_ready_o,
  output reg         done_o,
  output reg         test_flag_o,
  output reg         test_flag_valid_o,
  output reg         trap_o,
  output wire        irq_o
);

  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [31:0]               fr_q [0:15];
  reg [`FPAC_SC_W-1:0]     sc_q;
  reg [`FPAC_IRQ_W-1:0]    irq_st_q;
  reg [`FPAC_IRQ_W-1:0]    irq_en_q;
  reg [1:0]                st_q;
  reg [2:0]                cnt_q;
  reg [1:0]                op_q;
  reg [3:0]                dst_q;
  reg                      pr_q;
  reg [63:0]               a_q;
  reg [63:0]               b_q;

  // classify a wide operand; single values sit in the upper word
  function [2:0] cls;
    input [63:0] x;
    input        pr;
    input        dn;
    reg   [10:0] e;
    reg   [51:0] f;
    reg          emax;
    begin
      e    = pr ? x[62:52] : {3'h0, x[62:55]};
      f    = pr ? x[51:0] : {x[54:32], 29'h0};
      emax = pr ? (&x[62:52]) : (&x[62:55]);
      if (e == 11'h000)
        cls = (f == 52'h0 || dn) ? (x[63] ? `FPAC_C_NZERO : `FPAC_C_PZERO)
                                 : `FPAC_C_DENORM;
      else if (!emax)
        cls = `FPAC_C_NORM;
      else if (f == 52'h0)
        cls = x[63] ? `FPAC_C_NINF : `FPAC_C_PINF;
      else if (!f[51])
        cls = `FPAC_C_QNAN;
      else
        cls = `FPAC_C_SNAN;
    end
  endfunction

  // gather a single register or an even/odd pair into wide form
  function [63:0] fetch;
    input [3:0] idx;
    input       pr;
    begin
      fetch = pr ? {fr_q[{idx[3:1], 1'b0}], fr_q[{idx[3:1], 1'b1}]}
                 : {fr_q[idx], 32'h0};
    end
  endfunction

  // issue control; a new op is accepted only in idle
  wire       sel_now = st_q[0];
  wire       go      = sel_now & op_valid_i;
  wire       pr_now  = sc_q[`FPAC_SC_PR];
  wire [1:0] c_op    = sel_now ? op_code_i : op_q;
  wire [3:0] c_dst   = sel_now ? op_dst_i : dst_q;
  wire       c_pr    = sel_now ? pr_now : pr_q;
  wire [63:0] c_a    = sel_now ? fetch(op_dst_i, pr_now) : a_q;
  wire [63:0] c_b    = sel_now ? fetch(op_src_i, pr_now) : b_q;
  wire       dn      = sc_q[`FPAC_SC_DN];
  wire [4:0] en      = sc_q[`FPAC_SC_EN+4:`FPAC_SC_EN];
  wire [2:0] lat     = (op_code_i == `FPAC_OP_ADD && pr_now) ? `FPAC_LAT_ADDD :
                       (op_code_i == `FPAC_OP_CGT) ? `FPAC_LAT_CGT : `FPAC_LAT_ONE;
  assign op_ready_o = sel_now;
  wire   commit     = (go && lat == `FPAC_LAT_ONE) || (st_q[1] && cnt_q == `FPAC_LAT_ONE);

  wire [2:0] ca = cls(c_a, c_pr, dn);
  wire [2:0] cb = cls(c_b, c_pr, dn);

  // unpacked fields of both add operands
  wire [10:0] ea = c_pr ? c_a[62:52] : {3'h0, c_a[62:55]};
  wire [10:0] eb = c_pr ? c_b[62:52] : {3'h0, c_b[62:55]};
  wire [51:0] fa = c_pr ? c_a[51:0] : {c_a[54:32], 29'h0};
  wire [51:0] fb = c_pr ? c_b[51:0] : {c_b[54:32], 29'h0};

  // normal-operand add, round to nearest even at the active precision
  reg  [55:0] big, sml, lost, m;
  reg  [56:0] sum;
  reg  [12:0] ex, emaxv;
  reg  [10:0] eb_big, d;
  reg  [53:0] rnd;
  reg  [5:0]  lz;
  reg         sgn, g, st, up, sx;
  reg  [63:0] add_res;
  reg         add_o, add_u, add_i;
  integer     i;
  always @* begin
    sx    = ({ea, fa} < {eb, fb});
    big   = sx ? {1'b1, fb, 3'h0} : {1'b1, fa, 3'h0};
    sml   = sx ? {1'b1, fa, 3'h0} : {1'b1, fb, 3'h0};
    eb_big = sx ? eb : ea;
    sgn   = sx ? c_b[63] : c_a[63];
    d     = sx ? (eb - ea) : (ea - eb);
    // far-shifted bits fold into a sticky lsb so rounding still sees them
    lost  = (d > 11'd55) ? sml : (sml & ((56'h1 << d) - 56'h1));
    sml   = (d > 11'd55) ? 56'h0 : (sml >> d);
    sml[0] = sml[0] | (|lost);
    sum   = (c_a[63] == c_b[63]) ? ({1'b0, big} + {1'b0, sml})
                                 : ({1'b0, big} - {1'b0, sml});
    lz    = 6'h0;
    for (i = 0; i < 56; i = i + 1) begin
      if (sum[i])
        lz = 6'd55 - i[5:0];
    end
    if (sum[56]) begin
      m  = {sum[56:2], sum[1] | sum[0]};
      ex = {2'h0, eb_big} + 13'h1;
    end else begin
      m  = sum[55:0] << lz;
      ex = {2'h0, eb_big} - {7'h0, lz};
    end
    g     = c_pr ? m[2] : m[31];
    st    = c_pr ? (|m[1:0]) : (|m[30:0]);
    up    = g & (st | (c_pr ? m[3] : m[32]));
    rnd   = c_pr ? ({1'b0, m[55:3]} + {53'h0, up})
                 : ({1'b0, m[55:32], 29'h0} + {24'h0, up, 29'h0});
    if (rnd[53]) begin
      rnd = rnd >> 1;
      ex  = ex + 13'h1;
    end
    emaxv = c_pr ? `FPAC_EMAX_D : `FPAC_EMAX_S;
    add_i = g | st;
    add_o = ~ex[12] && (ex >= emaxv);
    add_u = ex[12] || (ex == 13'h0);
    if (sum == 57'h0) begin
      // exact cancellation gives positive zero
      add_res = 64'h0;
      add_i   = 1'b0;
      add_o   = 1'b0;
      add_u   = 1'b0;
    end else if (add_o) begin
      add_i   = 1'b1;
      add_res = c_pr ? {sgn, 11'h7ff, 52'h0} : {sgn, 8'hff, 55'h0};
    end else if (add_u) begin
      add_i   = 1'b1;
      add_res = {sgn, 63'h0};
    end else begin
      add_res = c_pr ? {sgn, ex[10:0], rnd[51:0]}
                     : {sgn, ex[7:0], rnd[51:29], 32'h0};
    end
  end

  // result, cause and write decision of the current operation
  reg [63:0] res;
  reg [5:0]  cause;
  reg        wr_res, trap, upd_cause, tf, tf_we, eq, gt;
  always @* begin
    res       = c_a;
    cause     = 6'h0;
    wr_res    = 1'b0;
    trap      = 1'b0;
    upd_cause = 1'b1;
    tf        = 1'b0;
    tf_we     = 1'b0;
    // zeros compare equal; otherwise sign-magnitude order
    eq = (c_a == c_b) ||
         ((ca == `FPAC_C_PZERO || ca == `FPAC_C_NZERO) &&
          (cb == `FPAC_C_PZERO || cb == `FPAC_C_NZERO));
    if (c_a[63] != c_b[63])
      gt = c_b[63];
    else
      gt = c_a[63] ? (c_a[62:0] < c_b[62:0]) : (c_a[62:0] > c_b[62:0]);
    gt = gt & ~eq;
    case (c_op)
      `FPAC_OP_ABS: begin
        res       = c_a & (c_pr ? `FPAC_SIGN_CLR : {1'b0, {31{1'b1}}, 32'h0});
        wr_res    = 1'b1;
        upd_cause = 1'b0;
      end
      `FPAC_OP_ADD: begin
        wr_res = 1'b1;
        if (ca == `FPAC_C_SNAN || cb == `FPAC_C_SNAN) begin
          cause[`FPAC_X_V] = 1'b1;
          res = c_pr ? `FPAC_QNAN_D : {`FPAC_QNAN_S, 32'h0};
        end else if (ca == `FPAC_C_QNAN || cb == `FPAC_C_QNAN) begin
          res = c_pr ? `FPAC_QNAN_D : {`FPAC_QNAN_S, 32'h0};
        end else if (ca == `FPAC_C_DENORM || cb == `FPAC_C_DENORM) begin
          cause[`FPAC_X_E] = 1'b1;
        end else begin
          case (cb)
            `FPAC_C_NORM: begin
              if (ca == `FPAC_C_NORM) begin
                res = add_res;
                cause[`FPAC_X_O] = add_o;
                cause[`FPAC_X_U] = add_u;
                cause[`FPAC_X_I] = add_i;
              end else if (ca == `FPAC_C_PZERO || ca == `FPAC_C_NZERO)
                res = c_b;
            end
            `FPAC_C_PZERO: res = (ca == `FPAC_C_NZERO) ? 64'h0 : c_a;
            `FPAC_C_PINF, `FPAC_C_NINF: begin
              if ((ca == `FPAC_C_PINF || ca == `FPAC_C_NINF) && ca != cb)
                cause[`FPAC_X_V] = 1'b1;
              res = c_b;
              if (cause[`FPAC_X_V])
                res = c_pr ? `FPAC_QNAN_D : {`FPAC_QNAN_S, 32'h0};
            end
            default: res = c_a;
          endcase
        end
        trap = cause[`FPAC_X_E] | (cause[`FPAC_X_V] & en[`FPAC_X_V]) |
               en[`FPAC_X_O] | en[`FPAC_X_U] | en[`FPAC_X_I];
        if (trap)
          wr_res = 1'b0;
      end
      default: begin
        // greater also invalid on quiet NaN
        if (ca == `FPAC_C_SNAN || cb == `FPAC_C_SNAN ||
            (c_op == `FPAC_OP_CGT && (ca == `FPAC_C_QNAN || cb == `FPAC_C_QNAN))) begin
          cause[`FPAC_X_V] = 1'b1;
          trap  = en[`FPAC_X_V];
          tf_we = ~en[`FPAC_X_V];
        end else if (ca == `FPAC_C_QNAN || cb == `FPAC_C_QNAN) begin
          tf_we = 1'b1;
        end else begin
          tf_we = 1'b1;
          tf    = (c_op == `FPAC_OP_CEQ) ? eq : gt;
        end
      end
    endcase
  end

  // sequencer: one-state ops finish at the accepting edge
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q  <= ST_IDLE;
      cnt_q <= 3'h0;
      op_q  <= `FPAC_OP_ABS;
      dst_q <= 4'h0;
      pr_q  <= 1'b0;
      a_q   <= 64'h0;
      b_q   <= 64'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (go && lat != `FPAC_LAT_ONE) begin
            st_q  <= ST_WAIT;
            cnt_q <= lat - `FPAC_LAT_ONE;
            op_q  <= op_code_i;
            dst_q <= op_dst_i;
            pr_q  <= pr_now;
            a_q   <= c_a;
            b_q   <= c_b;
          end
        end
        ST_WAIT: begin
          cnt_q <= cnt_q - `FPAC_LAT_ONE;
          if (cnt_q == `FPAC_LAT_ONE)
            st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // register file: a commit in the same cycle as a bus write wins
  integer k;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (k = 0; k < 16; k = k + 1)
        fr_q[k] <= 32'h0;
    end else begin
      if (reg_wr_i && reg_addr_i <= `FPAC_A_FR_TOP && reg_addr_i[1:0] == 2'h0)
        fr_q[reg_addr_i[5:2]] <= reg_wdata_i;
      if (commit && wr_res) begin
        if (c_pr) begin
          fr_q[{c_dst[3:1], 1'b0}] <= res[63:32];
          fr_q[{c_dst[3:1], 1'b1}] <= res[31:0];
        end else begin
          fr_q[c_dst] <= res[63:32];
        end
      end
    end
  end

  // status/control, result strobes and interrupt state
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sc_q              <= `FPAC_SC_RST;
      irq_st_q          <= {`FPAC_IRQ_W{1'b0}};
      irq_en_q          <= {`FPAC_IRQ_W{1'b0}};
      done_o            <= 1'b0;
      test_flag_o       <= 1'b0;
      test_flag_valid_o <= 1'b0;
      trap_o            <= 1'b0;
    end else begin
      done_o            <= commit;
      test_flag_valid_o <= commit & tf_we;
      trap_o            <= commit & trap;
      if (commit && tf_we)
        test_flag_o <= tf;
      if (reg_wr_i && reg_addr_i == `FPAC_A_CTRL)
        sc_q <= reg_wdata_i[`FPAC_SC_W-1:0];
      // hardware cause replaces; flags accumulate so software cannot lose one
      if (commit && upd_cause) begin
        sc_q[`FPAC_SC_CAUSE+5:`FPAC_SC_CAUSE] <= cause;
        sc_q[`FPAC_SC_FLAG+4:`FPAC_SC_FLAG] <= cause[4:0] |
          ((reg_wr_i && reg_addr_i == `FPAC_A_CTRL) ?
           reg_wdata_i[`FPAC_SC_FLAG+4:`FPAC_SC_FLAG] : sc_q[`FPAC_SC_FLAG+4:`FPAC_SC_FLAG]);
      end
      if (reg_wr_i && reg_addr_i == `FPAC_A_IRQ_EN)
        irq_en_q <= reg_wdata_i[`FPAC_IRQ_W-1:0];
      // set wins over a clear in the same cycle
      irq_st_q <= (irq_st_q & ~((reg_wr_i && reg_addr_i == `FPAC_A_IRQ_CLR) ?
                   reg_wdata_i[`FPAC_IRQ_W-1:0] : {`FPAC_IRQ_W{1'b0}})) |
                  ({commit & cause[`FPAC_X_E], commit & cause[`FPAC_X_V], commit & trap});
    end
  end

  assign irq_o = |(irq_st_q & irq_en_q);

  // read data one cycle after the strobe; unmapped reads return zero
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      if (reg_addr_i <= `FPAC_A_FR_TOP && reg_addr_i[1:0] == 2'h0)
        reg_rdata_o <= fr_q[reg_addr_i[5:2]];
      else if (reg_addr_i == `FPAC_A_CTRL)
        reg_rdata_o <= {{(32-`FPAC_SC_W){1'b0}}, sc_q};
      else if (reg_addr_i == `FPAC_A_IRQ_ST)
        reg_rdata_o <= {{(32-`FPAC_IRQ_W){1'b0}}, irq_st_q};
      else if (reg_addr_i == `FPAC_A_IRQ_EN)
        reg_rdata_o <= {{(32-`FPAC_IRQ_W){1'b0}}, irq_en_q};
      else
        reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

endmodule

// [testbench/fpac_cpu_model.sv]
`timescale 1ns/100ps
// decoder side: one request at a time, held until the unit takes it
module fpac_cpu_model (
  input  wire       clk_i,
  input  wire       op_ready_i,
  output reg        op_valid_o,
  output reg  [1:0] op_code_o,
  output reg  [3:0] op_dst_o,
  output reg  [3:0] op_src_o
);
  initial begin
    op_valid_o = 1'b0;
    op_code_o  = 2'h0;
    op_dst_o   = 4'h0;
    op_src_o   = 4'h0;
  end
  // call just after a rising edge; returns just after the taking edge
  task issue(input [1:0] c, input [3:0] d, input [3:0] s);
    integer k;
    begin
      op_valid_o <= 1'b1;
      op_code_o  <= c;
      op_dst_o   <= d;
      op_src_o   <= s;
      k = 0;
      @(posedge clk_i);
      while (!op_ready_i && k < 16) begin
        k = k + 1;
        @(posedge clk_i);
      end
      op_valid_o <= 1'b0;
      // released fields flip so a stale request cannot look valid
      op_code_o  <= ~c;
      op_dst_o   <= ~d;
      op_src_o   <= ~s;
    end
  endtask
endmodule

// [testbench/fpac_unit_properties.sv]
`timescale 1ns/100ps
`include "fpac_defs.vh"
module fpac_unit_checker (
  input wire        sys_clk_i,
  input wire        rst_i,
  input wire [7:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire        op_valid_i,
  input wire [1:0]  op_code_i,
  input wire        op_ready_o,
  input wire        done_o,
  input wire        test_flag_o,
  input wire        test_flag_valid_o,
  input wire        trap_o
);
  reg  pr_q;
  wire take;
  // shadow of precision_select: add length depends on it and it is not a port
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pr_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `FPAC_A_CTRL) begin
      pr_q <= reg_wdata_i[`FPAC_SC_PR];
    end
  end
  assign take = op_valid_i && op_ready_o;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_abs_one_state: assert property (take && op_code_i == `FPAC_OP_ABS |=>
    done_o && op_ready_o && !trap_o && !test_flag_valid_o) else $error("abs not clean");
  a_adds_one_state: assert property (take && op_code_i == `FPAC_OP_ADD && !pr_q |=>
    done_o && op_ready_o) else $error("single add not one state");
  a_addd_six_states: assert property (take && op_code_i == `FPAC_OP_ADD && pr_q |=>
    !op_ready_o [*5] ##1 (done_o && op_ready_o)) else $error("double add not six states");
  a_ceq_one_state: assert property (take && op_code_i == `FPAC_OP_CEQ |=>
    done_o && (test_flag_valid_o || trap_o)) else $error("compare-equal not one state");
  a_cgt_two_states: assert property (take && op_code_i == `FPAC_OP_CGT |=>
    !op_ready_o ##1 (done_o && (test_flag_valid_o || trap_o)))
    else $error("compare-greater not two states");
  a_trap_no_flag: assert property (trap_o |-> done_o && !test_flag_valid_o)
    else $error("trap without done or with flag write");
  a_flag_change_valid: assert property (!$past(rst_i) && test_flag_o != $past(test_flag_o)
    |-> test_flag_valid_o) else $error("test flag moved without a write");
  a_stall_no_done: assert property (!op_ready_o |-> !done_o)
    else $error("done while stalled");
  a_rdata_window: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind fpac_unit fpac_unit_checker i_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
  .op_ready_o(op_ready_o), .done_o(done_o), .test_flag_o(test_flag_o),
  .test_flag_valid_o(test_flag_valid_o), .trap_o(trap_o)
);

// [testbench/tb_top.sv]
`timescale 1ns/100ps
`include "fpac_defs.vh"
module tb_top;
  reg         sys_clk_i;
  reg         rst_i;
  reg  [7:0]  reg_addr_i;
  reg  [31:0] reg_wdata_i;
  reg         reg_wr_i;
  reg         reg_rd_i;
  wire [31:0] reg_rdata_o;
  wire        op_valid_i;
  wire [1:0]  op_code_i;
  wire [3:0]  op_dst_i;
  wire [3:0]  op_src_i;
  wire        op_ready_o;
  wire        done_o;
  wire        test_flag_o;
  wire        test_flag_valid_o;
  wire        trap_o;
  wire        irq_o;
  integer     bad_count;
  integer     n_checks;
  reg         t_seen;
  reg         f_seen;
  reg         f_val;
  fpac_unit i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
    .op_dst_i(op_dst_i), .op_src_i(op_src_i), .op_ready_o(op_ready_o),
    .done_o(done_o), .test_flag_o(test_flag_o), .test_flag_valid_o(test_flag_valid_o),
    .trap_o(trap_o), .irq_o(irq_o)
  );
  fpac_cpu_model i_cpu (
    .clk_i(sys_clk_i), .op_ready_i(op_ready_o), .op_valid_o(op_valid_i),
    .op_code_o(op_code_i), .op_dst_o(op_dst_i), .op_src_o(op_src_i)
  );
  // 50 MHz
  always #10 sys_clk_i = ~sys_clk_i;
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // bus tasks start just after an edge; the idle edge after a write avoids double drives
  task w(input [7:0] a, input [31:0] d);
    begin
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'b0;
      reg_wdata_i <= ~d;
      @(posedge sys_clk_i);
    end
  endtask
  task r(input [7:0] a, input [31:0] exp);
    begin
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge sys_clk_i);
      chk($sformatf("reg %h", a), exp, reg_rdata_o);
    end
  endtask
  // issue, then count edges up to the done pulse and capture its companions
  task run(input [1:0] c, input [3:0] d, input [3:0] s, input integer lat);
    integer k;
    begin
      i_cpu.issue(c, d, s);
      k = 1;
      @(posedge sys_clk_i);
      while (done_o !== 1'b1 && k < 20) begin
        k = k + 1;
        @(posedge sys_clk_i);
      end
      if (k == 20) begin
        bad_count = bad_count + 1;
        report_and_stop;
      end
      t_seen = trap_o;
      f_seen = test_flag_valid_o;
      f_val  = test_flag_o;
      chk("latency", lat, k);
    end
  endtask
  task t_regs;
    begin
      r(8'h40, 32'h0);
      w(8'h80, 32'hffffffff);
      r(8'h80, 32'h0);
      w(8'h3c, 32'h12345678);
      r(8'h3c, 32'h12345678);
    end
  endtask
  task t_add;
    begin
      w(8'h00, 32'h3f800000);
      w(8'h04, 32'h40000000);
      run(`FPAC_OP_ADD, 4'h0, 4'h1, 1);
      r(8'h00, 32'h40400000);
      w(8'h08, 32'h80000000);
      w(8'h0c, 32'h0);
      run(`FPAC_OP_ADD, 4'h2, 4'h3, 1);
      r(8'h08, 32'h0);
      w(8'h40, 32'h1);
      w(8'h10, 32'h3ff00000);
      w(8'h18, 32'h3ff00000);
      w(8'h1c, 32'h0);
      run(`FPAC_OP_ADD, 4'h4, 4'h6, 6);
      run(`FPAC_OP_ADD, 4'h4, 4'h6, 6);
      r(8'h10, 32'h40080000);
      r(8'h14, 32'h0);
      // double-width compares: 3.0 in pair 4 against 1.0 in pair 6
      run(`FPAC_OP_CGT, 4'h4, 4'h6, 2);
      chk("flagd", 32'h1, 32'(f_val));
      run(`FPAC_OP_CEQ, 4'h6, 4'h6, 1);
      chk("flagd", 32'h1, 32'(f_val));
      run(`FPAC_OP_CEQ, 4'h4, 4'h6, 1);
      chk("flagd", 32'h0, 32'(f_val));
    end
  endtask
  task t_spec;
    begin
      w(8'h40, 32'h0);
      w(8'h00, 32'h7fc00000);
      w(8'h04, 32'h7f800001);
      run(`FPAC_OP_ADD, 4'h0, 4'h1, 1);
      r(8'h00, `FPAC_QNAN_S);
      r(8'h40, 32'h00010800);
      w(8'h08, 32'h3f800000);
      run(`FPAC_OP_ADD, 4'h2, 4'h1, 1);
      r(8'h08, `FPAC_QNAN_S);
      r(8'h40, 32'h00000800);
      w(8'h08, 32'h3f800000);
      w(8'h0c, 32'h00000001);
      run(`FPAC_OP_ADD, 4'h2, 4'h3, 1);
      chk("trap", 32'h1, 32'(t_seen));
      r(8'h08, 32'h3f800000);
      r(8'h40, 32'h00020800);
      w(8'h40, 32'h2);
      run(`FPAC_OP_ADD, 4'h3, 4'h2, 1);
      chk("trap", 32'h0, 32'(t_seen));
      r(8'h0c, 32'h3f800000);
      w(8'h40, 32'h4);
      run(`FPAC_OP_ADD, 4'h2, 4'h2, 1);
      chk("trap", 32'h1, 32'(t_seen));
      r(8'h08, 32'h3f800000);
      // sticky status, masked, enabled, then one bit cleared
      r(8'h44, 32'h7);
      chk("irq", 32'h0, 32'(irq_o));
      w(8'h4c, 32'h4);
      chk("irq", 32'h1, 32'(irq_o));
      w(8'h48, 32'h4);
      chk("irq", 32'h0, 32'(irq_o));
      r(8'h44, 32'h3);
    end
  endtask
  task t_cmp;
    begin
      w(8'h40, 32'h0);
      w(8'h00, 32'h0);
      w(8'h04, 32'h80000000);
      w(8'h08, 32'h40000000);
      w(8'h0c, 32'h3f800000);
      w(8'h10, 32'h7f800001);
      w(8'h14, 32'h7fc00000);
      w(8'h18, 32'hc0400000);
      run(`FPAC_OP_CGT, 4'h0, 4'h1, 2);
      chk("flag", 32'h0, 32'(f_val));
      run(`FPAC_OP_CEQ, 4'h0, 4'h1, 1);
      chk("flag", 32'h1, 32'(f_val));
      run(`FPAC_OP_CEQ, 4'h4, 4'h4, 1);
      chk("flag", 32'h0, 32'(f_val));
      r(8'h40, 32'h0);
      run(`FPAC_OP_CGT, 4'h2, 4'h3, 2);
      chk("flag", 32'h1, 32'(f_val));
      run(`FPAC_OP_CGT, 4'h3, 4'h2, 2);
      chk("flag", 32'h0, 32'(f_val));
      run(`FPAC_OP_CGT, 4'h2, 4'h3, 2);
      run(`FPAC_OP_CGT, 4'h2, 4'h4, 2);
      chk("flag", 32'h0, 32'(f_val));
      r(8'h40, 32'h00010800);
      run(`FPAC_OP_ABS, 4'h6, 4'h0, 1);
      r(8'h18, 32'h40400000);
      r(8'h40, 32'h00010800);
      w(8'h40, 32'h1);
      w(8'h20, 32'hbff00000);
      w(8'h24, 32'h12345678);
      run(`FPAC_OP_ABS, 4'h8, 4'h0, 1);
      r(8'h20, 32'h3ff00000);
      r(8'h24, 32'h12345678);
      w(8'h40, 32'h40);
      run(`FPAC_OP_CEQ, 4'h5, 4'h2, 1);
      chk("trap", 32'h1, 32'(t_seen));
      chk("flagw", 32'h0, 32'(f_seen));
    end
  endtask
  task report_and_stop;
    begin
      if (bad_count == 0 && n_checks > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  // reset for four cycles, then the scenarios in turn
  initial begin
    bad_count   = 0;
    n_checks    = 0;
    sys_clk_i   = 1'b0;
    rst_i       = 1'b1;
    reg_addr_i  = 8'h0;
    reg_wdata_i = 32'h0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    t_regs;
    t_add;
    t_spec;
    t_cmp;
    report_and_stop;
  end
endmodule
